/* core/sacc_clk_div.sv */
// Conversion clock tick generator derived from the system clock
`timescale 1ns/1ns
module sacc_clk_div
    import sacc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic restart,
    input wire logic [7:0] divideValue,
    output logic tick
);

    logic [9:0] count_q;
    logic [9:0] last;

    // Period is four times one plus the divide value
    assign last = 10'(CLK_DIV_FACTOR * (int'(divideValue) + 1) - 1);

    // ----------------------------------------------------------------
    // Period counter, restarted at each conversion start
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_q <= 10'h000;
        end else if (ce) begin
            if (restart || count_q == last) begin
                count_q <= 10'h000;
            end else begin
                count_q <= count_q + 10'h001;
            end
        end
    end

    // One-cycle pulse at the end of each conversion clock period
    assign tick = ce && !restart && count_q == last;

endmodule // sacc_clk_div

/* core/sacc_device.sv */
// Converter end: sequencing, status flags and result alignment
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
// Functional notes
// - Mode low bits select 10, 12, 8 bits
// - 8-bit value in top bits, low four zero
// - 10-bit value in top bits, low two zero
// - Mode bit 3 low adds two-cycle calibration
// - Mode bit 2 low powers down after conversion
// - Reference select low picks internal, drives pin
// - Conversion clock period four times divide plus one
// - Host keeps conversion clock within 0.5-10 MHz
// - Inputs system-clock synchronous; start sampled on edge
// - Conversion start raises busy and sampling
// - Sample phase lasts two plus sample-time periods
// - Distribution drops sampling, keeps busy high
// - Distribution lasts one cycle per result bit
// - Host rounds sample time up for hold
// - Host meets monitor minimum sample times
// - One-cycle start; completion drops busy, raises valid
// - Result held; valid stays until next start
// - Busy covers calibration when enabled
// - New start abandons running conversion immediately
module sacc_device
    import sacc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    sacc_if.device link,
    input wire logic [11:0] analogCode,
    output logic powerDown,
    output logic referenceInternal,
    output logic referencePinOe,
    output logic [4:0] activeChannel,
    output logic calibrating
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Number of result bits for a resolution code
    function automatic logic [3:0] resBits(input logic [1:0] res);
        case (res)
            RES_12BIT: resBits = 4'hC;
            RES_8BIT: resBits = 4'h8;
            default: resBits = 4'hA;
        endcase
    endfunction

    // Left-align a converted value and zero the unused low bits
    function automatic logic [11:0] alignResult(input logic [11:0] code,
                                                input logic [1:0] res);
        case (res)
            RES_12BIT: alignResult = code;
            RES_8BIT: alignResult = {code[11:4], 4'h0};
            default: alignResult = {code[11:2], 2'h0};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    sacc_state_type state_q;
    logic [3:0] mode_q;
    logic [7:0] divide_q;
    logic [7:0] stime_q;
    logic [8:0] phaseCnt_q;
    logic [11:0] codeMeta_q;
    logic [11:0] codeSync_q;
    logic [11:0] held_q;
    logic [11:0] sar_q;
    logic [11:0] sarNext;
    logic [11:0] result_q;
    logic valid_q;
    logic powerDown_q;
    logic refSel_q;
    logic [4:0] chan_q;
    logic start;
    logic tick;
    logic [8:0] sampleLast;
    logic [8:0] distLast;
    logic [3:0] bitIdx;

    // Start is taken on any clock edge where it and ce are both high
    assign start = ce && link.conversionStart;

    // ----------------------------------------------------------------
    // Conversion clock
    // ----------------------------------------------------------------
    sacc_clk_div u_div (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .restart(start),
        .divideValue(divide_q),
        .tick(tick)
    );

    // Phase end counts from captured settings
    assign sampleLast = 9'(int'(stime_q) + SAMPLE_BASE_TICKS - 1);
    assign distLast = 9'(resBits(mode_q[1:0]) - 4'h1);
    assign bitIdx = 4'(4'hB - phaseCnt_q[3:0]);

    // ----------------------------------------------------------------
    // Analog code synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            codeMeta_q <= 12'h000;
            codeSync_q <= 12'h000;
        end else if (ce) begin
            codeMeta_q <= analogCode;
            codeSync_q <= codeMeta_q;
        end
    end

    // ----------------------------------------------------------------
    // Settings capture at conversion start
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_RESET;
            divide_q <= DIVIDE_RESET;
            stime_q <= STIME_RESET;
            chan_q <= 5'h00;
        end else if (start) begin
            mode_q <= link.mode;
            divide_q <= link.clockDivideValue;
            stime_q <= link.sampleTimeValue;
            chan_q <= link.channel;
        end
    end

    // Reference select follows its input every cycle that ce is high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refSel_q <= 1'b0;
        end else if (ce) begin
            refSel_q <= link.referenceSelect;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer: sample, distribution, optional calibration
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            phaseCnt_q <= 9'h000;
        end else if (start) begin
            state_q <= ST_SAMPLE;
            phaseCnt_q <= 9'h000;
        end else if (tick) begin
            case (state_q)
                ST_SAMPLE: begin
                    if (phaseCnt_q == sampleLast) begin
                        state_q <= ST_DISTRIB;
                        phaseCnt_q <= 9'h000;
                    end else begin
                        phaseCnt_q <= phaseCnt_q + 9'h001;
                    end
                end
                ST_DISTRIB: begin
                    phaseCnt_q <= phaseCnt_q + 9'h001;
                    if (phaseCnt_q == distLast) begin
                        phaseCnt_q <= 9'h000;
                        if (!mode_q[MODE_CAL_OFF_BIT]) begin
                            state_q <= ST_CAL;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_CAL: begin
                    phaseCnt_q <= phaseCnt_q + 9'h001;
                    if (phaseCnt_q == 9'(CAL_TICKS - 1)) begin
                        state_q <= ST_IDLE;
                        phaseCnt_q <= 9'h000;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    phaseCnt_q <= 9'h000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Approximation register, one bit per distribution cycle
    // ----------------------------------------------------------------
    // Value including this cycle's bit, so the last bit reaches the result
    always_comb begin
        sarNext = sar_q;
        if (tick && state_q == ST_DISTRIB) begin
            sarNext[bitIdx] = held_q[bitIdx];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            held_q <= 12'h000;
            sar_q <= 12'h000;
        end else if (start) begin
            sar_q <= 12'h000;
        end else if (tick) begin
            if (state_q == ST_SAMPLE && phaseCnt_q == sampleLast) begin
                held_q <= codeSync_q; // Hold at end of sampling
            end
            sar_q <= sarNext;
        end
    end

    // ----------------------------------------------------------------
    // Completion: latch result, raise valid
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result_q <= 12'h000;
            valid_q <= 1'b0;
        end else if (start) begin
            valid_q <= 1'b0;
        end else if (ce && state_q != ST_IDLE) begin
            if (state_q != ST_SAMPLE && !busyNext()) begin
                result_q <= alignResult(sarNext, mode_q[1:0]);
                valid_q <= 1'b1;
            end
        end
    end

    // True while the sequencer will still be running next cycle
    function automatic logic busyNext();
        busyNext = 1'b1;
        if (tick && state_q == ST_DISTRIB && phaseCnt_q == distLast &&
            mode_q[MODE_CAL_OFF_BIT]) begin
            busyNext = 1'b0;
        end
        if (tick && state_q == ST_CAL &&
            phaseCnt_q == 9'(CAL_TICKS - 1)) begin
            busyNext = 1'b0;
        end
    endfunction

    // Power-down after completion unless mode bit 2 keeps it on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            powerDown_q <= 1'b0;
        end else if (start) begin
            powerDown_q <= 1'b0;
        end else if (ce && state_q != ST_IDLE && state_q != ST_SAMPLE &&
                     !busyNext()) begin
            powerDown_q <= !mode_q[MODE_STAY_ON_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.busy = state_q != ST_IDLE;
    assign link.sampling = state_q == ST_SAMPLE;
    assign link.resultValid = valid_q;
    assign link.result = result_q;
    assign powerDown = powerDown_q;
    assign referenceInternal = !refSel_q;
    assign referencePinOe = !refSel_q;
    assign activeChannel = chan_q;
    assign calibrating = state_q == ST_CAL;

endmodule // sacc_device

/* core/sacc_host.sv */
// Controlling end: APB registers driving the converter link
`timescale 1ns/1ns
module sacc_host
    import sacc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sacc_if.host link
);

    logic [3:0] mode_q;
    logic refSel_q;
    logic [4:0] chan_q;
    logic [7:0] divide_q;
    logic [7:0] stime_q;
    logic start_q;
    logic access;
    logic wr;
    logic mapped;

    // Access phase; every mapped access completes in one cycle
    assign access = psel && penable && ce;
    assign wr = access && pwrite;
    assign mapped = paddr == REG_CTRL || paddr == REG_DIVIDE ||
                    paddr == REG_STIME || paddr == REG_START ||
                    paddr == REG_STATUS || paddr == REG_RESULT;

    // ----------------------------------------------------------------
    // Setting registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_RESET;
            refSel_q <= 1'b0;
            chan_q <= 5'h00;
            divide_q <= DIVIDE_RESET;
            stime_q <= STIME_RESET;
        end else if (wr) begin
            if (paddr == REG_CTRL) begin
                mode_q <= pwdata[CTRL_MODE_LSB +: MODE_W];
                refSel_q <= pwdata[CTRL_REFSEL_BIT];
                chan_q <= pwdata[CTRL_CHAN_LSB +: CHAN_W];
            end
            if (paddr == REG_DIVIDE) begin
                divide_q <= pwdata[7:0];
            end
            if (paddr == REG_STIME) begin
                stime_q <= pwdata[7:0];
            end
        end
    end

    // Start pulse, one system clock wide, from a write to START
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b0;
        end else if (ce) begin
            start_q <= wr && paddr == REG_START && pwdata[0];
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && psel && !penable && !pwrite) begin
            case (paddr)
                REG_CTRL: prdata <= {19'h0, chan_q, 3'h0, refSel_q, mode_q};
                REG_DIVIDE: prdata <= {24'h0, divide_q};
                REG_STIME: prdata <= {24'h0, stime_q};
                REG_STATUS: prdata <= {29'h0, link.resultValid,
                                       link.sampling, link.busy};
                REG_RESULT: prdata <= {20'h0, link.result};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Link drive, all synchronous to the system clock
    assign link.mode = mode_q;
    assign link.clockDivideValue = divide_q;
    assign link.sampleTimeValue = stime_q;
    assign link.channel = chan_q;
    assign link.referenceSelect = refSel_q;
    assign link.conversionStart = start_q;

endmodule // sacc_host

/* core/sacc_if.sv */
// Link between the controlling logic and the converter control block
`timescale 1ns/1ns
interface sacc_if;
    logic [3:0] mode;
    logic [7:0] clockDivideValue;
    logic [7:0] sampleTimeValue;
    logic [4:0] channel;
    logic referenceSelect;
    logic conversionStart;
    logic busy;
    logic sampling;
    logic resultValid;
    logic [11:0] result;

    // Converter end
    modport device (
        input mode,
        input clockDivideValue,
        input sampleTimeValue,
        input channel,
        input referenceSelect,
        input conversionStart,
        output busy,
        output sampling,
        output resultValid,
        output result
    );

    // Controlling logic end
    modport host (
        output mode,
        output clockDivideValue,
        output sampleTimeValue,
        output channel,
        output referenceSelect,
        output conversionStart,
        input busy,
        input sampling,
        input resultValid,
        input result
    );
endinterface

/* core/sacc_pkg.sv */
// Shared constants and types for the converter control block
package sacc_pkg;

    // ----------------------------------------------------------------
    // Mode word layout
    // ----------------------------------------------------------------
    localparam int MODE_W = 4;
    localparam int MODE_CAL_OFF_BIT = 3;
    localparam int MODE_STAY_ON_BIT = 2;
    localparam logic [1:0] RES_10BIT = 2'h0;
    localparam logic [1:0] RES_12BIT = 2'h1;
    localparam logic [1:0] RES_8BIT = 2'h2;
    localparam int RESULT_W = 12;
    localparam int CHAN_W = 5;
    localparam int DIVIDE_W = 8;
    localparam int STIME_W = 8;

    // ----------------------------------------------------------------
    // Timing counts, in conversion-clock or system-clock cycles
    // ----------------------------------------------------------------
    localparam int CLK_DIV_FACTOR = 4;
    localparam int SAMPLE_BASE_TICKS = 2;
    localparam int CAL_TICKS = 2;
    localparam int TICK_CNT_W = 10;
    localparam int PHASE_CNT_W = 9;

    // ----------------------------------------------------------------
    // Host register map (byte addresses) and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIVIDE = 8'h04;
    localparam logic [7:0] REG_STIME = 8'h08;
    localparam logic [7:0] REG_START = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RESULT = 8'h14;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_REFSEL_BIT = 4;
    localparam int CTRL_CHAN_LSB = 8;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [7:0] DIVIDE_RESET = 8'h00;
    localparam logic [7:0] STIME_RESET = 8'h00;

    // Conversion sequence states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_DISTRIB,
        ST_CAL
    } sacc_state_type;

endpackage

/* tb/sacc_properties.sv */
// Timing and result checks on the converter link signals
`timescale 1ns/1ns
module sacc_properties
    import sacc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] mode,
    input wire logic [7:0] clockDivideValue,
    input wire logic [7:0] sampleTimeValue,
    input wire logic conversionStart,
    input wire logic busy,
    input wire logic sampling,
    input wire logic resultValid,
    input wire logic [11:0] result
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    int periodW;
    int bitsW;
    int sampQ;
    int totalQ;
    int cntQ;
    logic [1:0] resQ;

    // Tick period and bits from the live settings
    assign periodW = CLK_DIV_FACTOR * (1 + int'(clockDivideValue));
    assign bitsW = (mode[1:0] == RES_12BIT) ? 12 :
                   (mode[1:0] == RES_8BIT) ? 8 : 10;

    // Expected phase lengths, captured at each start
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sampQ <= 0;
            totalQ <= 0;
            resQ <= 2'h0;
        end else if (conversionStart) begin
            sampQ <= periodW * (2 + int'(sampleTimeValue));
            totalQ <= periodW * (2 + int'(sampleTimeValue) + bitsW +
                                 (mode[3] ? 0 : CAL_TICKS));
            resQ <= mode[1:0];
        end
    end

    // Busy cycles since the last start
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cntQ <= 0;
        end else if (conversionStart) begin
            cntQ <= 0;
        end else if (busy) begin
            cntQ <= cntQ + 1;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_start_flags;
        conversionStart |=> busy && sampling && !resultValid;
    endproperty
    a_start_flags: assert property (p_start_flags)
        else $error("flags wrong after start");

    property p_valid_low;
        $rose(busy) |-> !resultValid [*8];
    endproperty
    a_valid_low: assert property (p_valid_low)
        else $error("valid high during conversion");

    property p_sample_len;
        $fell(sampling) |-> busy && cntQ == sampQ;
    endproperty
    a_sample_len: assert property (p_sample_len)
        else $error("sample phase length wrong");

    property p_busy_len;
        $fell(busy) |-> cntQ == totalQ && resultValid;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");

    property p_valid_hold;
        resultValid && !conversionStart |=> resultValid;
    endproperty
    a_valid_hold: assert property (p_valid_hold)
        else $error("valid dropped without start");

    property p_result_hold;
        !$rose(resultValid) |-> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed while latched");

    property p_align8;
        $rose(resultValid) && resQ == RES_8BIT |-> result[3:0] == 4'h0;
    endproperty
    a_align8: assert property (p_align8)
        else $error("low four bits not zero");

    property p_align10;
        $rose(resultValid) && resQ != RES_8BIT && resQ != RES_12BIT
            |-> result[1:0] == 2'h0;
    endproperty
    a_align10: assert property (p_align10)
        else $error("low two bits not zero");

    property p_samp_busy;
        sampling |-> busy;
    endproperty
    a_samp_busy: assert property (p_samp_busy)
        else $error("sampling without busy");
endmodule // sacc_properties

/* tb/sacc_tb.sv */
// Self-checking bench: APB host end joined to the converter end
`timescale 1ns/1ns
module sacc_tb
    import sacc_pkg::*;
;
    logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr, errW;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdW;
    logic [11:0] analogCode;
    logic powerDown, referenceInternal, referencePinOe, calibrating;
    logic [4:0] activeChannel;
    logic [15:0] lfsrQ, codeW;
    logic [3:0] m;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    int busyCnt = 0;

    sacc_if u_sacc_if ();
    sacc_host u_sacc_host (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(u_sacc_if.host));
    sacc_device u_sacc_device (.mclk(mclk), .rst(rst), .ce(ce),
        .link(u_sacc_if.device), .analogCode(analogCode),
        .powerDown(powerDown), .referenceInternal(referenceInternal),
        .referencePinOe(referencePinOe), .activeChannel(activeChannel),
        .calibrating(calibrating));
    sacc_properties u_sacc_properties (.mclk(mclk), .rst(rst),
        .mode(u_sacc_if.mode), .clockDivideValue(u_sacc_if.clockDivideValue),
        .sampleTimeValue(u_sacc_if.sampleTimeValue),
        .conversionStart(u_sacc_if.conversionStart), .busy(u_sacc_if.busy),
        .sampling(u_sacc_if.sampling), .resultValid(u_sacc_if.resultValid),
        .result(u_sacc_if.result));

    // ----------------------------------------------------------------
    // Clock, busy counter and hang guard
    // ----------------------------------------------------------------
    initial mclk = 1'h0;
    always #25 mclk = ~mclk;

    always @(posedge mclk) begin
        busyCnt <= u_sacc_if.conversionStart ? 0 : busyCnt + u_sacc_if.busy;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic int exp_busy(input logic [3:0] md, input int dv,
                                    input int st);
        int n;
        n = (md[1:0] == 2'h1) ? 12 : (md[1:0] == 2'h2) ? 8 : 10;
        return 4 * (1 + dv) * (2 + st + n + (md[3] ? 0 : 2));
    endfunction

    function automatic logic [11:0] exp_res(input logic [11:0] c,
                                            input logic [1:0] r);
        if (r == 2'h1) return c;
        if (r == 2'h2) return {c[11:4], 4'h0};
        return {c[11:2], 2'h0};
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp,
                           input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask

    // One APB transfer; waits for pready at each access edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rdW = prdata;
        errW = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic err);
        apb(1'h0, a, 32'h0);
        chk_word(rdW, exp, "read data");
        chk_bit(errW, err, "slave error");
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Optionally start one, configure, convert over the running one, compare
    task automatic convert(input logic [3:0] md, input logic [7:0] dv,
                           input logic [7:0] st, input logic [4:0] ch,
                           input logic rf, input logic [11:0] c,
                           input logic inject);
        logic [31:0] ctrl;
        ctrl = {19'h0, ch, 3'h0, rf, md};
        if (inject) apb(1'h1, REG_START, 32'h1);
        apb(1'h1, REG_CTRL, ctrl);
        apb(1'h1, REG_DIVIDE, {24'h0, dv});
        apb(1'h1, REG_STIME, {24'h0, st});
        analogCode <= c;
        rd_chk(REG_CTRL, ctrl, 1'h0);
        if (inject) chk_bit(u_sacc_if.resultValid, 1'h0, "inject");
        apb(1'h1, REG_START, 32'h1);
        apb(1'h1, REG_DIVIDE, {24'h0, 8'h09 - dv});
        do @(posedge mclk); while (u_sacc_if.resultValid !== 1'h1);
        chk_word(busyCnt, exp_busy(md, dv, st),
                 "busy");
        chk_word({20'h0, u_sacc_if.result}, {20'h0, exp_res(c, md[1:0])},
                 "res");
        chk_bit(powerDown, ~md[2], "power down");
        chk_bit(referenceInternal, ~rf, "ref internal");
        chk_bit(referencePinOe, ~rf, "ref pin");
        chk_word({27'h0, activeChannel}, {27'h0, ch}, "channel");
        rd_chk(REG_STATUS, 32'h4, 1'h0);
        rd_chk(REG_RESULT, {20'h0, exp_res(c, md[1:0])}, 1'h0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        analogCode = 12'h000;
        lfsrQ = 16'h3E7C;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        chk_bit(u_sacc_if.busy, 1'h0, "reset busy");
        chk_bit(u_sacc_if.resultValid, 1'h0, "reset valid");
        chk_bit(referenceInternal, 1'h1, "reset ref");
        rd_chk(REG_CTRL, 32'h0, 1'h0);
        rd_chk(REG_DIVIDE, 32'h0, 1'h0);
        ce <= 1'h0;
        apb(1'h1, REG_DIVIDE, 32'h5);
        ce <= 1'h1;
        rd_chk(REG_DIVIDE, 32'h0, 1'h0);
        apb(1'h1, REG_RESULT, 32'hFFF);
        rd_chk(REG_RESULT, 32'h0, 1'h0);
        rd_chk(8'h20, 32'h0, 1'h1);
        for (int i = 0; i < 12; i++) begin
            lfsrQ = lfsr_next(lfsrQ);
            codeW = lfsr_next(lfsrQ);
            m = {i[2], i[3] ^ i[0], i[1:0]};
            convert(m, (i == 2) ? 8'h09 : (i == 0) ? 8'h00 :
                    {6'h0, lfsrQ[1:0]},
                    (i == 1) ? 8'hFF : (i < 3) ? 8'h00 : {5'h0, lfsrQ[4:2]},
                    lfsrQ[9:5], lfsrQ[10], codeW[11:0], i % 4 == 3);
        end
        give_verdict();
    end
endmodule // sacc_tb
